// File: core/pcs_pkg.sv
// Constants for the configuration status register of the USB host controller.
// Assumes one clock domain and configuration accesses of 16-bit width.
package pcs_pkg;

    // Byte offset of the status register in configuration space.
    localparam logic [7:0]  PCS_STATUS_OFFSET   = 8'h06;

    // Field positions inside the status word.
    localparam int          PCS_BIT_DET_PAR     = 15;
    localparam int          PCS_BIT_SIG_SERR    = 14;
    localparam int          PCS_BIT_RCV_MABORT  = 13;
    localparam int          PCS_BIT_RCV_TABORT  = 12;
    localparam int          PCS_BIT_SIG_TABORT  = 11;
    localparam int          PCS_BIT_DEVSEL_HI   = 10;
    localparam int          PCS_BIT_DEVSEL_LO   = 9;
    localparam int          PCS_BIT_DATA_PAR    = 8;
    localparam int          PCS_BIT_FBB_CAP     = 7;
    localparam int          PCS_BIT_UDF         = 6;
    localparam int          PCS_BIT_66MHZ       = 5;
    localparam int          PCS_RSVD_HI         = 4;
    localparam int          PCS_RSVD_LO         = 0;

    // Bits that hold a sticky flag; every other bit is a constant.
    localparam logic [15:0] PCS_FLAG_MASK       = 16'hf900;

    // Byte lane that carries all the flags.
    localparam int          PCS_FLAG_LANE       = 1;

    // Reset and fixed values.
    localparam logic        PCS_FLAG_RESET      = 1'b0;
    localparam logic [1:0]  PCS_DEVSEL_MEDIUM   = 2'h1;
    localparam logic        PCS_FBB_CAP_VAL     = 1'b0;
    localparam logic        PCS_UDF_VAL         = 1'b0;
    localparam logic        PCS_66MHZ_VAL       = 1'b0;
    localparam logic [4:0]  PCS_RSVD_VAL        = 5'h00;
    localparam logic [15:0] PCS_RDATA_RESET     = 16'h0000;

    // The parity error response enable of the command register is wired off.
    localparam logic        PCS_PAR_RESP_EN     = 1'b0;

    // State of one sticky flag cell.
    typedef struct packed {
        logic flag;
    } pcs_cell_s;

    // State of the register bank's read port.
    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
    } pcs_bank_s;

endpackage

// File: core/pcs_flag_cell.sv
// One sticky status flag: set by a hardware event, cleared by software.
// Assumes set and clear are single-cycle requests in the clk domain.
`timescale 1ns/100ps
module pcs_flag_cell
    import pcs_pkg::*;
(
    input  wire logic clk,      // Internal bus clock.
    input  wire logic sys_rst,  // Synchronous reset, active high.
    input  wire logic set_evt,  // Event that raises the flag.
    input  wire logic clr_req,  // Software clear of the flag.
    output logic      flag      // Current flag value.
);

    pcs_cell_s state_reg;
    pcs_cell_s state_next;

    // An event in the same cycle as a clear must not be lost, so set wins.
    always_comb begin
        state_next = state_reg;
        if (set_evt) begin
            state_next.flag = 1'b1;
        end else if (clr_req) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.flag <= PCS_FLAG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

endmodule

// File: core/pcs_status_reg.sv
// Configuration status register of the USB host controller.
// Assumes configuration accesses and bus engine events share clk.
//
// Contract
// - Bit 15 sets on a detected data or address parity error.
// - Bit 14 sets whenever the device has driven system error.
// - Bit 13 sets when own master cycle ends in master abort.
// - Bit 12 sets when own master cycle ends in target abort.
// - Bit 11 sets when device as target signals target abort.
// - Writing 0 to bits 15, 14, 13, 12, 11 or 8 clears that flag.
// - Bits 10:9 are read-only and read medium timing code 01.
// - Bit 8 needs parity error, master role and response enable.
// - Response enable is wired off, so bit 8 always reads 0.
// - Bit 7 is read-only zero: no fast back-to-back support.
// - Bit 6 is read-only zero: no user-definable features.
// - Reserved bits 4:0 always read 0; software writes them 0.
`timescale 1ns/100ps
module pcs_status_reg
    import pcs_pkg::*;
#(
    parameter int DATA_W = 16,  // Width of the status word.
    parameter int ADDR_W = 8    // Width of the configuration byte address.
)
(
    input  wire logic              clk,          // Internal bus clock.
    input  wire logic              sys_rst,      // Sync reset, active high.
    input  wire logic              cfg_rd,       // Read strobe, one cycle.
    input  wire logic              cfg_wr,       // Write strobe, one cycle.
    input  wire logic [ADDR_W-1:0] cfg_addr,     // Byte address of access.
    input  wire logic [1:0]        cfg_be,       // Byte enables, high.
    input  wire logic [DATA_W-1:0] cfg_wdata,    // Write data.
    input  wire logic              par_err_det,  // Parity error seen, pulse.
    input  wire logic              serr_drive,   // System error driven.
    input  wire logic              mst_mabort,   // Master abort, pulse.
    input  wire logic              mst_tabort,   // Target abort seen, pulse.
    input  wire logic              tgt_tabort,   // Target abort given, pulse.
    input  wire logic              perr_seen,    // Parity error line seen.
    input  wire logic              master_cycle, // Device is bus master.
    output logic [DATA_W-1:0]      cfg_rdata,    // Registered read data.
    output logic                   cfg_rvalid    // Read data valid, pulse.
);

    pcs_bank_s         state_reg;
    pcs_bank_s         state_next;

    logic              addr_hit;
    logic              flag_wr;
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] clr_vec;
    logic [DATA_W-1:0] flag_vec;
    logic [DATA_W-1:0] status_word;

    assign addr_hit = (cfg_addr == PCS_STATUS_OFFSET);

    // Only the upper byte lane carries flags, so only it can clear them.
    assign flag_wr = cfg_wr && addr_hit && cfg_be[PCS_FLAG_LANE];

    // Hardware events that raise the sticky flags.
    always_comb begin
        set_vec = '0;
        set_vec[PCS_BIT_DET_PAR]    = par_err_det;
        set_vec[PCS_BIT_SIG_SERR]   = serr_drive;
        set_vec[PCS_BIT_RCV_MABORT] = mst_mabort;
        set_vec[PCS_BIT_RCV_TABORT] = mst_tabort;
        set_vec[PCS_BIT_SIG_TABORT] = tgt_tabort;
        // The enable is a constant off, so this term can never fire.
        set_vec[PCS_BIT_DATA_PAR]   = perr_seen && master_cycle
                                      && PCS_PAR_RESP_EN;
    end

    // A zero written to a flag position clears it; a one is ignored.
    always_comb begin
        clr_vec = '0;
        if (flag_wr) begin
            clr_vec = ~cfg_wdata & PCS_FLAG_MASK;
        end
    end

    // One sticky cell per flag position; other positions stay zero here.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_bit
            if (PCS_FLAG_MASK[gi]) begin : g_flag
                pcs_flag_cell u_cell (
                    .clk     (clk),
                    .sys_rst (sys_rst),
                    .set_evt (set_vec[gi]),
                    .clr_req (clr_vec[gi]),
                    .flag    (flag_vec[gi])
                );
            end else begin : g_fixed
                assign flag_vec[gi] = 1'b0;
            end
        end
    endgenerate

    // Read view: sticky flags merged with the fixed capability fields.
    always_comb begin
        status_word = flag_vec & PCS_FLAG_MASK;
        status_word[PCS_BIT_DEVSEL_HI:PCS_BIT_DEVSEL_LO]
            = PCS_DEVSEL_MEDIUM;
        status_word[PCS_BIT_FBB_CAP] = PCS_FBB_CAP_VAL;
        status_word[PCS_BIT_UDF]     = PCS_UDF_VAL;
        status_word[PCS_BIT_66MHZ]   = PCS_66MHZ_VAL;
        status_word[PCS_RSVD_HI:PCS_RSVD_LO] = PCS_RSVD_VAL;
    end

    // The answer is registered so the read data comes from a flop; the
    // cost is one cycle of latency, and a read in the same cycle as an
    // event shows the flag value from before that event.
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = cfg_rd;
        if (cfg_rd) begin
            if (addr_hit) begin
                state_next.rdata = status_word;
            end else begin
                state_next.rdata = PCS_RDATA_RESET;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.rdata  <= PCS_RDATA_RESET;
            state_reg.rvalid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_rdata  = state_reg.rdata;
    assign cfg_rvalid = state_reg.rvalid;

endmodule

// File: dv/pcs_status_sva.sv
// Assertions on the status register ports.
// Bound to pcs_status_reg; one clock, sync reset.
`timescale 1ns/100ps
module pcs_status_sva (
    input wire logic        clk,         // Clock.
    input wire logic        sys_rst,     // Reset.
    input wire logic        cfg_rd,      // Read.
    input wire logic [7:0]  cfg_addr,    // Address.
    input wire logic        par_err_det, // Parity.
    input wire logic        serr_drive,  // Sys error.
    input wire logic        mst_mabort,  // M abort.
    input wire logic        mst_tabort,  // T abort in.
    input wire logic        tgt_tabort,  // T abort out.
    input wire logic [15:0] cfg_rdata,   // Data.
    input wire logic        cfg_rvalid   // Valid.
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic rd6 = cfg_rd && cfg_addr == 8'h06;
    a_perr_set: assert property (
        par_err_det ##1 rd6 |=> cfg_rdata[15]) else $error("bit 15");
    a_serr_set: assert property (
        serr_drive ##1 rd6 |=> cfg_rdata[14]) else $error("bit 14");
    a_mabort_set: assert property (
        mst_mabort ##1 rd6 |=> cfg_rdata[13]) else $error("bit 13");
    a_tabort_set: assert property (
        mst_tabort ##1 rd6 |=> cfg_rdata[12]) else $error("bit 12");
    a_tgt_abort_set: assert property (
        tgt_tabort ##1 rd6 |=> cfg_rdata[11]) else $error("bit 11");
    a_devsel_code: assert property (
        rd6 |=> cfg_rvalid && cfg_rdata[10:9] == 2'h1) else $error("timing");
    a_parity_zero: assert property (
        cfg_rvalid |-> !cfg_rdata[8]) else $error("bit 8 set");
    a_fixed_zero: assert property (
        cfg_rvalid |-> cfg_rdata[7:0] == 8'h00) else $error("low byte");
endmodule
bind pcs_status_reg pcs_status_sva u_sva (.*);

// File: dv/pcs_bus_model.sv
// Bus engine model: raises event strobes for one cycle each.
// Driven by the bench through req; events land one edge later.
`timescale 1ns/100ps
module pcs_bus_model (
    input wire logic       clk, // Clock.
    input wire logic [6:0] req, // Events wanted.
    output logic     [6:0] evt  // Event strobes.
);
    initial evt = 7'h00;
    always @(posedge clk) evt <= req;
endmodule

// File: dv/pci_config_status_register_tb_top.sv
// Bench for the status register: reads, writes and bus events.
// Assumes pcs_bus_model feeds the event inputs.
`timescale 1ns/100ps
module pci_config_status_register_tb_top import pcs_pkg::*;;
    logic clk = 1'b0, sys_rst = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0, cfg_rvalid;
    logic [7:0]  cfg_addr = PCS_STATUS_OFFSET;
    logic [1:0]  cfg_be = 2'h0;
    logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, e = 16'h0200;
    logic [6:0]  req = 7'h00, evt;
    int          n_mismatch = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    pcs_bus_model u_model (.*);
    pcs_status_reg DUT (.*, .par_err_det(evt[0]), .serr_drive(evt[1]),
        .mst_mabort(evt[2]), .mst_tabort(evt[3]), .tgt_tabort(evt[4]),
        .perr_seen(evt[5]), .master_cycle(evt[6]));
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("mismatch at %0t: %h not %h", $time, got, exp);
    endtask
    task automatic rd(input logic [15:0] x, input logic [7:0] a = 8'h06);
        @(posedge clk);
        {cfg_rd, cfg_addr} <= {1'b1, a};
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        cmp({cfg_rvalid, cfg_rdata}, {1'b1, x});
    endtask
    task automatic drv(input logic [6:0] r, input logic w, input logic [17:0] d);
        @(posedge clk);
        {req, cfg_wr, cfg_be, cfg_wdata} <= {r, w, d};
        @(posedge clk);
        {req, cfg_wr} <= 8'h00;
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(16'h0000, 8'h04);
        rd(16'h0200);
        for (int i = 0; i < 5; i++) begin
            drv(7'h60 | 7'h01 << i, 1'b0, 18'h00000);
            e = e | 16'h8000 >> i;
            rd(e);
        end
        drv(7'h00, 1'b1, 18'h10000);
        rd(16'hfa00);
        drv(7'h00, 1'b1, 18'h2dfe0);
        rd(16'hda00);
        drv(7'h00, 1'b1, 18'h20000);
        rd(16'h0200);
        // A reset in mid-run must drop a flag that is set again here.
        drv(7'h10, 1'b0, 18'h00000);
        rd(16'h0a00);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(16'h0200);
        conclude();
    end
endmodule
